// file: hct_channel.sv
// Host channel transaction control with APB register slave
//
// How it works
// - No answer or handshake in time: retry
// - CRC or bit stuffing error: retry
// - Bad PID check or unknown PID: retry
// - Split interrupt ERR or three NYETs: retry
// - Toggle mismatch gives retry; other codes reserved
// - Count ACKs, flag at programmed threshold
// - Threshold zero means sixteen ACKs
// - Two-bit speed select: HS, FS, LS
// - Toggle bit seeds, then reads live toggle
// - Write one starts, write zero requests stop
// - Start bit reads as running indicator
// - Full count: complete flag, start clears
// - Condition flag clears start, records code
// - Stop finishes current packet, then flags
// - Stop keeps count and settings for resume
// - Token field selects OUT or IN
// - Transfer field selects bulk or interrupt
// - OUT exact boundary appends zero-length packet
// - Unlimited bit ignores the byte count
// - Total register reads remaining bytes
// - Result codes: none, stall, overrun, underrun, retry
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "hct_params.svh"

module hct_channel (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Packet engine results, one pulse per finished packet
    input  wire logic        eng_pkt_done,
    input  wire logic [9:0]  eng_pkt_bytes,
    input  wire logic        eng_timeout,
    input  wire logic        eng_crc_err,
    input  wire logic        eng_stuff_err,
    input  wire logic        eng_pid_chk_err,
    input  wire logic        eng_pid_invalid,
    input  wire logic        eng_err_hs,
    input  wire logic        eng_nyet,
    input  wire logic        eng_toggle_mm,
    input  wire logic        eng_stall,
    input  wire logic        eng_split,
    // Channel settings towards the packet engine
    output logic             xact_start_run,
    output logic      [1:0]  token_dir,
    output logic      [1:0]  xfer_kind,
    output logic      [1:0]  target_speed_sel,
    output logic             data_toggle,
    output logic             zlp_send,
    output logic      [9:0]  max_pkt_size,
    // Event flags, readable also in the status register
    output logic             xfer_complete_flag,
    output logic             ack_reached_flag,
    output logic             cond_changed_flag
);

    // ---------------------------------------------------------------
    // Address helpers
    // ---------------------------------------------------------------

    // Byte address of a register index
    function automatic logic [11:0] reg_addr(input logic [9:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    hct_pkg::hct_state_t state_q, state_d;   // Sequencer
    logic [3:0]  ack_thr_q;                  // ACK threshold field
    logic [1:0]  speed_q;                    // Target speed field
    logic        toggle_q, toggle_d;         // Live data toggle
    logic        run_q, run_d;               // Start / running bit
    logic [1:0]  tok_q;                      // Token direction
    logic [1:0]  kind_q;                     // Transfer kind
    logic        zlp_en_q;                   // Auto zero-length enable
    logic        free_q;                     // Unlimited size enable
    logic [9:0]  maxpkt_q;                   // Max packet size
    logic [31:0] rem_q, rem_d;               // Remaining byte count
    logic [2:0]  code_q, code_d;             // Result code
    logic        stop_q, stop_d;             // Stop requested
    logic [4:0]  ack_cnt_q, ack_cnt_d;       // ACKs since last flag
    logic [1:0]  nyet_q, nyet_d;             // Consecutive NYETs
    logic        cmp_q, ackf_q, cond_q;      // Sticky status flags
    logic        zlp_q;                      // Zero-length packet owed
    logic [31:0] prdata_q;                   // Read data
    logic        pready_q;                   // Access completion
    logic        pslverr_q;                  // Unmapped access

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    wire access   = psel & penable;
    wire fire     = access & pready_q;
    wire wr_fire  = fire & pwrite;
    wire hit_ctl  = (paddr == reg_addr(`HCT_IDX_CONTROL));
    wire hit_set  = (paddr == reg_addr(`HCT_IDX_SETUP));
    wire hit_max  = (paddr == reg_addr(`HCT_IDX_MAXPKT));
    wire hit_tot  = (paddr == reg_addr(`HCT_IDX_TOTAL));
    wire hit_res  = (paddr == reg_addr(`HCT_IDX_RESULT));
    wire hit_sta  = (paddr == reg_addr(`HCT_IDX_STATUS));
    wire mapped   = hit_ctl | hit_set | hit_max | hit_tot | hit_res
                  | hit_sta;
    wire wr_ctl   = wr_fire & hit_ctl;
    wire wr_set   = wr_fire & hit_set;
    wire wr_max   = wr_fire & hit_max;
    wire wr_tot   = wr_fire & hit_tot;
    wire wr_sta   = wr_fire & hit_sta;
    wire idle     = (state_q == hct_pkg::HCT_IDLE);

    // Read multiplexer
    wire [31:0] rd_ctl = {24'h000000, ack_thr_q, speed_q, toggle_q,
                          run_q};
    wire [31:0] rd_set = {24'h000000, tok_q, kind_q, zlp_en_q, 2'b00,
                          free_q};
    wire [31:0] rd_mux =
        hit_ctl ? rd_ctl :
        hit_set ? rd_set :
        hit_max ? {22'h000000, maxpkt_q} :
        hit_tot ? rem_q :
        hit_res ? {25'h0000000, code_q, 4'h0} :
        hit_sta ? {29'h00000000, cond_q, ackf_q, cmp_q} :
                  32'h00000000;

    // ---------------------------------------------------------------
    // Software start and stop
    // ---------------------------------------------------------------
    // Start on one
    wire sw_start = wr_ctl & pwdata[`HCT_CTL_RUN_BIT] & idle;
    wire sw_stop  = wr_ctl & ~pwdata[`HCT_CTL_RUN_BIT] & ~idle;

    // ---------------------------------------------------------------
    // Packet result classification
    // ---------------------------------------------------------------
    wire is_out   = (tok_q == `HCT_TOK_OUT);
    wire is_intr  = (kind_q == `HCT_KIND_INTR);
    wire pkt      = eng_pkt_done & ~idle;
    wire [31:0] pkt_len = {22'h000000, eng_pkt_bytes};

    wire nyet3    = eng_split & is_intr & eng_nyet
                  & (nyet_q == `HCT_NYET_LIMIT);
    wire retry    = eng_timeout | eng_crc_err | eng_stuff_err
                  | eng_pid_chk_err | eng_pid_invalid
                  | (eng_split & is_intr & eng_err_hs) | nyet3
                  | eng_toggle_mm;
    // Overrun when too long for packet or what remains
    wire overrun  = ~is_out & ((eng_pkt_bytes > maxpkt_q)
                  | (~free_q & (pkt_len > rem_q)));
    // Underrun on short IN packet before the count ends
    wire underrun = ~is_out & (eng_pkt_bytes < maxpkt_q)
                  & (free_q | (pkt_len < rem_q));
    // NYET other than the third split interrupt NYET is a hold-off, not data
    wire holdoff  = eng_nyet & ~nyet3;
    wire fault    = retry | eng_stall | overrun;
    wire good     = pkt & ~fault & ~holdoff;
    wire [31:0] rem_after = rem_q - pkt_len;
    // Unlimited transfer never completes on count
    wire count_end = ~free_q & (rem_after == 32'h00000000);
    // OUT packet ending exactly on a packet boundary
    wire need_zlp = zlp_en_q & is_out & (eng_pkt_bytes == maxpkt_q);

    wire [4:0] ack_limit = (ack_thr_q == 4'h0) ? 5'h10
                                               : {1'b0, ack_thr_q};
    wire ack_hit  = good & ((ack_cnt_q + 5'h01) == ack_limit);

    // Event pulses for the status flags
    logic set_cmp, set_cond;

    // ---------------------------------------------------------------
    // Sequencer
    // ---------------------------------------------------------------
    // Decides the next state, count, toggle and result per packet
    always_comb begin
        state_d   = state_q;
        run_d     = run_q;
        toggle_d  = toggle_q;
        rem_d     = rem_q;
        code_d    = code_q;
        stop_d    = stop_q | sw_stop;
        ack_cnt_d = ack_cnt_q;
        nyet_d    = nyet_q;
        set_cmp   = 1'b0;
        set_cond  = 1'b0;
        case (state_q)
            hct_pkg::HCT_IDLE: begin
                // Toggle written by software while stopped
                if (wr_ctl) begin
                    toggle_d = pwdata[`HCT_CTL_TOG_BIT];
                end
                // Count loaded by software while stopped
                if (wr_tot) begin
                    rem_d = pwdata;
                end
                if (sw_start) begin
                    run_d   = 1'b1;
                    state_d = hct_pkg::HCT_RUN;
                    stop_d  = 1'b0;
                    nyet_d  = 2'b00;
                end
            end
            hct_pkg::HCT_RUN, hct_pkg::HCT_ZLP: begin
                if (pkt) begin
                    // NYET run length for split interrupt
                    nyet_d = eng_nyet ? nyet_q + 2'b01 : 2'b00;
                    if (good) begin
                        toggle_d  = ~toggle_q;
                        ack_cnt_d = ack_hit ? 5'h00
                                            : ack_cnt_q + 5'h01;
                    end
                    if (retry) begin
                        code_d = `HCT_RC_RETRY;
                    end else if (eng_stall) begin
                        code_d = `HCT_RC_STALL;
                    end else if (overrun) begin
                        code_d = `HCT_RC_OVERRUN;
                    end else if (~holdoff && underrun &&
                                 state_q == hct_pkg::HCT_RUN) begin
                        code_d = `HCT_RC_UNDERRUN;
                    end else begin
                        code_d = `HCT_RC_NO_ERROR;
                    end
                    if (good && state_q == hct_pkg::HCT_RUN) begin
                        if (!free_q) begin
                            rem_d = rem_after;
                        end
                    end
                    if (fault) begin
                        run_d    = 1'b0;
                        set_cond = 1'b1;
                        state_d  = hct_pkg::HCT_IDLE;
                    end else if (good &&
                                 state_q == hct_pkg::HCT_ZLP) begin
                        run_d   = 1'b0;
                        set_cmp = 1'b1;
                        state_d = hct_pkg::HCT_IDLE;
                    end else if (good && count_end) begin
                        if (need_zlp && !stop_d) begin
                            state_d = hct_pkg::HCT_ZLP;
                        end else begin
                            run_d   = 1'b0;
                            set_cmp = 1'b1;
                            state_d = hct_pkg::HCT_IDLE;
                        end
                    end else if (good && underrun) begin
                        run_d    = 1'b0;
                        set_cond = 1'b1;
                        state_d  = hct_pkg::HCT_IDLE;
                    end else if (stop_d) begin
                        // Stop after the packet in flight
                        // Count and settings kept for resume
                        run_d    = 1'b0;
                        set_cond = 1'b1;
                        state_d  = hct_pkg::HCT_IDLE;
                    end
                end
            end
            default: begin
                state_d = hct_pkg::HCT_IDLE;
                run_d   = 1'b0;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Sequencer registers
    // ---------------------------------------------------------------
    // All control state cleared on reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q   <= hct_pkg::HCT_IDLE;
            run_q     <= 1'b0;
            toggle_q  <= 1'b0;
            rem_q     <= 32'h00000000;
            code_q    <= `HCT_RC_NO_ERROR;
            stop_q    <= 1'b0;
            ack_cnt_q <= 5'h00;
            nyet_q    <= 2'b00;
            zlp_q     <= 1'b0;
        end else begin
            state_q   <= state_d;
            run_q     <= run_d;
            toggle_q  <= toggle_d;
            rem_q     <= rem_d;
            code_q    <= code_d;
            stop_q    <= (state_d == hct_pkg::HCT_IDLE) ? 1'b0 : stop_d;
            ack_cnt_q <= ack_cnt_d;
            nyet_q    <= nyet_d;
            zlp_q     <= (state_d == hct_pkg::HCT_ZLP);
        end
    end

    // ---------------------------------------------------------------
    // Configuration registers
    // ---------------------------------------------------------------
    // Threshold and speed writable any time; setup only when idle
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ack_thr_q <= 4'h0;
            speed_q   <= 2'b00;
            tok_q     <= 2'b00;
            kind_q    <= 2'b00;
            zlp_en_q  <= 1'b0;
            free_q    <= 1'b0;
            maxpkt_q  <= 10'h000;
        end else begin
            if (wr_ctl) begin
                ack_thr_q <= pwdata[7:4];
                speed_q   <= pwdata[3:2];
            end
            if (wr_set && idle) begin
                tok_q    <= pwdata[7:6];
                kind_q   <= pwdata[5:4];
                zlp_en_q <= pwdata[`HCT_SET_ZLP_BIT];
                free_q   <= pwdata[`HCT_SET_FREE_BIT];
            end
            if (wr_max && idle) begin
                maxpkt_q <= pwdata[9:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Sticky status flags, write one to clear, set wins
    // ---------------------------------------------------------------
    wire clr_cmp  = wr_sta & pwdata[`HCT_ST_CMP_BIT];
    wire clr_ack  = wr_sta & pwdata[`HCT_ST_ACK_BIT];
    wire clr_cond = wr_sta & pwdata[`HCT_ST_COND_BIT];

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmp_q  <= 1'b0;
            ackf_q <= 1'b0;
            cond_q <= 1'b0;
        end else begin
            cmp_q  <= set_cmp | (cmp_q & ~clr_cmp);
            ackf_q <= ack_hit | (ackf_q & ~clr_ack);
            cond_q <= set_cond | (cond_q & ~clr_cond);
        end
    end

    // ---------------------------------------------------------------
    // APB response, one wait state per access
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q  <= access & ~pready_q;
            prdata_q  <= (access & ~pready_q & ~pwrite) ? rd_mux
                                                         : 32'h00000000;
            pslverr_q <= access & ~pready_q & ~mapped;
        end
    end

    // ---------------------------------------------------------------
    // Outputs, all from flip-flops
    // ---------------------------------------------------------------
    assign prdata             = prdata_q;
    assign pready             = pready_q;
    assign pslverr            = pslverr_q;
    assign xact_start_run     = run_q;
    assign token_dir          = tok_q;
    assign xfer_kind          = kind_q;
    assign target_speed_sel   = speed_q;
    assign data_toggle        = toggle_q;
    assign zlp_send           = zlp_q;
    assign max_pkt_size       = maxpkt_q;
    assign xfer_complete_flag = cmp_q;
    assign ack_reached_flag   = ackf_q;
    assign cond_changed_flag  = cond_q;

endmodule
`default_nettype wire

// file: hct_params.svh
// Register indices, field positions and codes of the host channel block
`ifndef HCT_PARAMS_SVH
`define HCT_PARAMS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define HCT_IDX_CONTROL   10'h1c0
`define HCT_IDX_SETUP     10'h1c1
`define HCT_IDX_MAXPKT    10'h1c2
`define HCT_IDX_TOTAL     10'h1c4
`define HCT_IDX_RESULT    10'h1c8
`define HCT_IDX_STATUS    10'h1c9

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define HCT_CTL_RUN_BIT   0
`define HCT_CTL_TOG_BIT   1
`define HCT_SET_FREE_BIT  0
`define HCT_SET_ZLP_BIT   3
`define HCT_ST_CMP_BIT    0
`define HCT_ST_ACK_BIT    1
`define HCT_ST_COND_BIT   2

// ---------------------------------------------------------------
// Reset values and encodings
// ---------------------------------------------------------------
`define HCT_CFG_RESET     8'h00
`define HCT_RC_NO_ERROR   3'h0
`define HCT_RC_STALL      3'h1
`define HCT_RC_OVERRUN    3'h2
`define HCT_RC_UNDERRUN   3'h3
`define HCT_RC_RETRY      3'h4
`define HCT_TOK_OUT       2'h1
`define HCT_TOK_IN        2'h2
`define HCT_KIND_BULK     2'h2
`define HCT_KIND_INTR     2'h3
`define HCT_NYET_LIMIT    2'h2

`endif

// file: hct_pkg.sv
// Types shared by the host channel transaction block
package hct_pkg;

    // Channel sequencing states
    typedef enum logic [1:0] {
        HCT_IDLE,
        HCT_RUN,
        HCT_ZLP
    } hct_state_t;

endpackage

// file: hct_channel_chk.sv
// Concurrent checks on the host channel ports
`timescale 1ns/1ps
`default_nettype none
`include "hct_params.svh"
module hct_channel_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       sys_rst,
    // Register bus
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic       pready,
    // Engine results
    input wire logic       eng_pkt_done,
    input wire logic       eng_timeout,
    input wire logic       eng_crc_err,
    input wire logic       eng_toggle_mm,
    input wire logic       eng_err_hs,
    input wire logic       eng_split,
    // Channel state
    input wire logic       xact_start_run,
    input wire logic [1:0] token_dir,
    input wire logic [1:0] xfer_kind,
    input wire logic       data_toggle,
    input wire logic       zlp_send,
    input wire logic       xfer_complete_flag,
    input wire logic       cond_changed_flag
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    // Packet taken while running, and a retry fault
    wire logic take = eng_pkt_done && xact_start_run;
    wire logic flt  = eng_timeout || eng_crc_err || eng_toggle_mm;
    // Bus phases
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_wait;
        psel && penable && !pready;
    endsequence
    chk_apb_wait: assert property (s_setup ##1 s_wait |=> pready)
        else $error("bus answer not in second access cycle");
    chk_retry_stop: assert property (take && flt |=>
        !xact_start_run && cond_changed_flag) else $error("fault kept run");
    chk_split_err: assert property (take && eng_split && eng_err_hs &&
        xfer_kind == `HCT_KIND_INTR |=> !xact_start_run && cond_changed_flag)
        else $error("split error not flagged");
    chk_fault_tog: assert property (take && flt |=> $stable(data_toggle))
        else $error("toggle moved on fault");
    chk_cmp_stop: assert property ($rose(xfer_complete_flag) |->
        !xact_start_run) else $error("complete without stop");
    chk_cond_stop: assert property ($rose(cond_changed_flag) |->
        !xact_start_run) else $error("condition without stop");
    chk_idle_hold: assert property (!xact_start_run &&
        !(psel && penable && pwrite && pready) |=> !xact_start_run)
        else $error("run rose without a write");
    chk_zlp_out: assert property (zlp_send |->
        token_dir == `HCT_TOK_OUT) else $error("zero-length on IN");
endmodule
`default_nettype wire

// file: hct_ep_model.sv
// Behavioural endpoint giving packet outcomes to the channel
`timescale 1ns/1ps
`default_nettype none
module hct_ep_model (
    // Clock
    input wire logic        clk_sys,
    // Packet outcome
    output logic            eng_pkt_done,
    output logic      [9:0] eng_pkt_bytes,
    output logic            eng_timeout,
    output logic            eng_crc_err,
    output logic            eng_stuff_err,
    output logic            eng_pid_chk_err,
    output logic            eng_pid_invalid,
    output logic            eng_err_hs,
    output logic            eng_nyet,
    output logic            eng_toggle_mm,
    output logic            eng_stall,
    output logic            eng_split
);
    logic [8:0] qual_q;  // Outcome qualifiers, bit per kind
    assign {eng_stall, eng_toggle_mm, eng_nyet, eng_err_hs, eng_pid_invalid,
            eng_pid_chk_err, eng_stuff_err, eng_crc_err, eng_timeout} = qual_q;
    initial begin
        eng_pkt_done  = 1'b0;
        eng_pkt_bytes = 10'h155;
        qual_q        = 9'h0;
        eng_split     = 1'b0;
    end
    // One packet after a delay; bytes show junk when idle
    task automatic send(input logic [9:0] b, input logic [8:0] q, input int slow);
        repeat (slow) @(posedge clk_sys);
        @(posedge clk_sys);
        eng_pkt_done  <= 1'b1;
        eng_pkt_bytes <= b;
        qual_q        <= q;
        @(posedge clk_sys);
        eng_pkt_done  <= 1'b0;
        eng_pkt_bytes <= ~b;
        qual_q        <= 9'h0;
    endtask
    // Mark split transactions
    task automatic set_split(input logic v);
        @(posedge clk_sys);
        eng_split <= v;
    endtask
endmodule
`default_nettype wire

// file: tb_hct_channel.sv
// Self-checking bench for the host channel block
`timescale 1ns/1ps
`default_nettype none
`include "hct_params.svh"
module tb_hct_channel;
    localparam logic [11:0] A_CTL = {`HCT_IDX_CONTROL, 2'b00};
    localparam logic [11:0] A_SET = {`HCT_IDX_SETUP, 2'b00};
    localparam logic [11:0] A_MPK = {`HCT_IDX_MAXPKT, 2'b00};
    localparam logic [11:0] A_TOT = {`HCT_IDX_TOTAL, 2'b00};
    localparam logic [11:0] A_RES = {`HCT_IDX_RESULT, 2'b00};
    localparam logic [11:0] A_STS = {`HCT_IDX_STATUS, 2'b00};
    logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        rerr, eng_pkt_done, eng_timeout, eng_crc_err, eng_stuff_err;
    logic        eng_pid_chk_err, eng_pid_invalid, eng_err_hs, eng_nyet;
    logic        eng_toggle_mm, eng_stall, eng_split, xact_start_run;
    logic [9:0]  eng_pkt_bytes, max_pkt_size;
    logic [1:0]  token_dir, xfer_kind, target_speed_sel;
    logic        data_toggle, zlp_send, xfer_complete_flag;
    logic        ack_reached_flag, cond_changed_flag;
    int          fails, n_checks;
    hct_channel  i_hct_channel (.*);
    hct_ep_model i_hct_ep_model (.*);
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Verdict and end of run
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic ck(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One bus transfer: setup, access, wait for ready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd   = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        ck(rd, e);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    // Program a transfer and start it
    task automatic go(input logic [7:0] s, input logic [31:0] t, input logic [7:0] c);
        wr(A_SET, 32'(s));
        wr(A_MPK, 32'h40);
        wr(A_TOT, t);
        wr(A_CTL, 32'(c));
    endtask
    initial begin
        repeat (20000) @(posedge clk_sys);
        fails++;
        close_out;
    end
    initial begin
        {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 44'h0};
        fails    = 0;
        n_checks = 0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        rc(A_CTL, 32'h0);
        rc(A_SET, 32'h0);
        // Unlimited IN bulk, sixteen acks at threshold zero
        go(8'ha1, 32'h0, 8'h01);
        for (int i = 1; i <= 16; i++) begin
            i_hct_ep_model.send(10'h40, 9'h0, i % 3);
            if (i >= 15) rc(A_STS, i == 16 ? 32'h2 : 32'h0);
        end
        rc(A_CTL, 32'h01);
        wr(A_CTL, 32'h0);
        i_hct_ep_model.send(10'h40, 9'h0, 0);
        rc(A_CTL, 32'h02);
        wr(A_STS, 32'h7);
        // OUT bulk, exact boundary, auto zero-length
        go(8'h68, 32'h80, 8'h25);
        @(negedge clk_sys);
        ck(32'(token_dir), 32'(`HCT_TOK_OUT));
        ck(32'(xfer_kind), 32'(`HCT_KIND_BULK));
        i_hct_ep_model.send(10'h40, 9'h0, 2);
        rc(A_TOT, 32'h40);
        rc(A_CTL, 32'h27);
        i_hct_ep_model.send(10'h40, 9'h0, 0);
        @(negedge clk_sys);
        ck(32'(zlp_send), 32'h1);
        rc(A_STS, 32'h2);
        i_hct_ep_model.send(10'h0, 9'h0, 1);
        rc(A_STS, 32'h3);
        rc(A_CTL, 32'h26);
        wr(A_STS, 32'h7);
        // Each retry kind except ERR and NYET, and stall, on IN bulk
        for (int i = 0; i < 9; i++) begin
            if (i == 5 || i == 6) continue;
            go(8'ha0, 32'h40, 8'h03);
            i_hct_ep_model.send(10'h40, 9'(1 << i), 0);
            rc(A_RES, i == 8 ? 32'h10 : 32'h40);
            rc(A_CTL, 32'h02);
            rc(A_STS, 32'h4);
            wr(A_STS, 32'h7);
        end
        // Split interrupt: NYETs, then error handshake
        i_hct_ep_model.set_split(1'b1);
        go(8'hb0, 32'h40, 8'h01);
        repeat (2) i_hct_ep_model.send(10'h0, 9'h040, 1);
        rc(A_CTL, 32'h01);
        i_hct_ep_model.send(10'h0, 9'h040, 0);
        rc(A_RES, 32'h40);
        wr(A_STS, 32'h7);
        wr(A_CTL, 32'h01);
        i_hct_ep_model.send(10'h0, 9'h020, 0);
        rc(A_RES, 32'h40);
        i_hct_ep_model.set_split(1'b0);
        wr(A_STS, 32'h7);
        // Stop mid-transfer, then resume
        go(8'ha0, 32'h80, 8'h01);
        wr(A_CTL, 32'h0);
        i_hct_ep_model.send(10'h40, 9'h0, 3);
        rc(A_STS, 32'h4);
        rc(A_RES, 32'h0);
        rc(A_TOT, 32'h40);
        wr(A_STS, 32'h7);
        wr(A_CTL, 32'h03);
        i_hct_ep_model.send(10'h40, 9'h0, 0);
        rc(A_STS, 32'h1);
        rc(A_CTL, 32'h0);
        // Speed codes
        for (int s = 0; s < 4; s++) begin
            if (s == 2) continue;
            wr(A_CTL, s << 2);
            @(negedge clk_sys);
            ck(32'(target_speed_sel), s);
        end
        // Unmapped address is refused
        apb(1'b0, 12'h7fc, 32'h0);
        ck(32'(rerr), 32'h1);
        ck(rd, 32'h0);
        close_out;
    end
endmodule
bind hct_channel hct_channel_chk i_hct_channel_chk (.*);
`default_nettype wire
